// [core/ppsi_pkg.sv]
// constants and carrier types of the per-port status and event register bank
package ppsi_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [9:0]  IDX_LINK_STATUS   = 10'h126;
    localparam logic [9:0]  IDX_SYM_ERR_COUNT = 10'h12A;
    localparam logic [9:0]  IDX_EVENT_CTRL    = 10'h136;
    localparam logic [9:0]  IDX_XOVER         = 10'h138;
    localparam logic [9:0]  IDX_IRQ_STATUS    = 10'h140;
    localparam logic [9:0]  IDX_IRQ_MASK      = 10'h141;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int LS_GIG_BIT   = 1;
    localparam int LS_FAST_BIT  = 0;
    localparam int NUM_EVENTS   = 8;
    localparam int EN_SHIFT     = 8;
    localparam int EV_JABBER    = 7;
    localparam int EV_RX_ERROR  = 6;
    localparam int EV_PAGE_RX   = 5;
    localparam int EV_PAR_FAULT = 4;
    localparam int EV_LP_ACK    = 3;
    localparam int EV_LINK_DOWN = 2;
    localparam int EV_REM_FAULT = 1;
    localparam int EV_LINK_UP   = 0;
    localparam int XO_FORCE_BIT = 7;
    localparam int XO_OFF_BIT   = 6;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [15:0] XOVER_RST  = 16'h2400;
    localparam logic [15:0] CNT_RST    = 16'h0000;
    localparam logic [7:0]  EN_RST     = 8'h00;
    localparam logic [7:0]  FLAGS_RST  = 8'h00;
    localparam logic [7:0]  MASK_RST   = 8'h00;
    localparam logic [31:0] RDATA_RST  = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic gig_up;
        logic fast_up;
    } ppsi_link_t;

    typedef struct packed {
        logic jabber;
        logic rx_error;
        logic page_rx;
        logic par_det_fault;
        logic lp_ack;
        logic remote_fault;
    } ppsi_phy_events_t;

endpackage : ppsi_pkg

// [core/ppsi_port_regs.sv]
// per-port link status, error counter, event and crossover registers on apb
//
// Behaviour
// R01 - read-only status word: bit 1 gigabit link up, bit 0 100 Mb/s link up
// R02 - 16-bit errored-frame counter, resets to zero, cleared when software reads it
// R03 - bit 15 enables jabber interrupt, flag bit 7, enable resets disabled
// R04 - bit 14 enables receive-error interrupt, flag bit 6, resets disabled
// R05 - bit 13 enables page-received interrupt, flag bit 5, resets disabled
// R06 - bit 12 enables parallel-detect-fault interrupt, flag bit 4, resets disabled
// R07 - bit 11 enables link-partner-acknowledge interrupt, flag bit 3, resets disabled
// R08 - bit 10 enables link-down interrupt, flag bit 2 on link loss
// R09 - bit 9 enables remote-fault interrupt, flag bit 1, resets disabled
// R10 - bit 8 enables link-up interrupt, flag bit 0 on link gain
// R11 - flags 7:0 read-only, reset 0, latch events, clear on read
// R12 - crossover-disable bit 6 stops automatic mdi/mdi-x resolution, resets to 0
// R13 - while crossover disabled, bit 7 forces mdi when 1, mdi-x when 0
// R14 - flags latch regardless of enable; request while any enabled flag set
// R15 - counter saturates at maximum, counts each errored frame once
`timescale 1ns/1ps
`default_nettype none
module ppsi_port_regs #(
    parameter int ADDR_W = 12
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ADDR_W-1:0]         paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire ppsi_pkg::ppsi_link_t       link_status,
    input  wire ppsi_pkg::ppsi_phy_events_t phy_events,
    input  wire logic                      sym_err_frame,
    input  wire logic                      auto_mdi_straight,
    output logic                           auto_crossover_en,
    output logic                           forced_straight_select,
    output logic                           mdi_straight_sel,
    output logic                           port_irq_req,
    output logic                           irq
);

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic idx_hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
        return (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
    endfunction : idx_hit

    wire logic hit_link   = idx_hit(paddr, ppsi_pkg::IDX_LINK_STATUS);
    wire logic hit_cnt    = idx_hit(paddr, ppsi_pkg::IDX_SYM_ERR_COUNT);
    wire logic hit_ctrl   = idx_hit(paddr, ppsi_pkg::IDX_EVENT_CTRL);
    wire logic hit_xover  = idx_hit(paddr, ppsi_pkg::IDX_XOVER);
    wire logic hit_status = idx_hit(paddr, ppsi_pkg::IDX_IRQ_STATUS);
    wire logic hit_mask   = idx_hit(paddr, ppsi_pkg::IDX_IRQ_MASK);
    wire logic mapped     = hit_link | hit_cnt | hit_ctrl | hit_xover | hit_status | hit_mask;

    wire logic setup_ph   = psel & ~penable;
    wire logic access_ph  = psel & penable;
    wire logic wr_ok      = access_ph & pwrite & mapped;
    wire logic rd_ok      = access_ph & ~pwrite & mapped;

    wire logic wr_ctrl    = wr_ok & hit_ctrl;
    wire logic wr_xover   = wr_ok & hit_xover;
    wire logic wr_status  = wr_ok & hit_status;
    wire logic wr_mask    = wr_ok & hit_mask;
    wire logic rd_ctrl    = rd_ok & hit_ctrl;
    wire logic rd_cnt     = rd_ok & hit_cnt;

    // zero wait states, unmapped or misaligned answers with an error
    assign pready  = 1'b1;
    assign pslverr = access_ph & ~mapped;

    ////////////////////////////////////////////////////////////////////////////
    // link edges

    logic link_prev_reg;
    wire logic link_any = link_status.gig_up | link_status.fast_up;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_prev_reg <= 1'b0;
        end else begin
            link_prev_reg <= link_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event vector

    logic [ppsi_pkg::NUM_EVENTS-1:0] ev_vec;

    assign ev_vec[ppsi_pkg::EV_JABBER]    = phy_events.jabber;
    assign ev_vec[ppsi_pkg::EV_RX_ERROR]  = phy_events.rx_error;
    assign ev_vec[ppsi_pkg::EV_PAGE_RX]   = phy_events.page_rx;
    assign ev_vec[ppsi_pkg::EV_PAR_FAULT] = phy_events.par_det_fault;
    assign ev_vec[ppsi_pkg::EV_LP_ACK]    = phy_events.lp_ack;
    // R08 link loss edge
    assign ev_vec[ppsi_pkg::EV_LINK_DOWN] = link_prev_reg & ~link_any;
    assign ev_vec[ppsi_pkg::EV_REM_FAULT] = phy_events.remote_fault;
    // R10 link gain edge
    assign ev_vec[ppsi_pkg::EV_LINK_UP]   = link_any & ~link_prev_reg;

    ////////////////////////////////////////////////////////////////////////////
    // read data register, captured in setup phase

    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic [15:0] cnt_val;
    logic [7:0]  en_reg;
    logic [7:0]  ev_flags;
    logic [15:0] xover_reg;
    logic [7:0]  irq_status;
    logic [7:0]  mask_reg;

    // R01 link status word
    wire logic [15:0] link_word = {14'h0000, link_status.gig_up, link_status.fast_up};
    wire logic [15:0] ctrl_word = {en_reg, ev_flags};

    always_comb begin
        prdata_next = ppsi_pkg::RDATA_RST;
        if (hit_link) begin
            prdata_next = {16'h0000, link_word};
        end else if (hit_cnt) begin
            prdata_next = {16'h0000, cnt_val};
        end else if (hit_ctrl) begin
            prdata_next = {16'h0000, ctrl_word};
        end else if (hit_xover) begin
            prdata_next = {16'h0000, xover_reg};
        end else if (hit_status) begin
            prdata_next = {24'h00_0000, irq_status};
        end else if (hit_mask) begin
            prdata_next = {24'h00_0000, mask_reg};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= ppsi_pkg::RDATA_RST;
        end else if (setup_ph && !pwrite) begin
            prdata_reg <= prdata_next;
        end
    end

    assign prdata = prdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // errored-frame counter

    // R02 clear on read, R15 saturate
    ppsi_sat_counter #(
        .WIDTH   (16),
        .RST_VAL (ppsi_pkg::CNT_RST)
    ) u_sym_err_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (sym_err_frame),
        .clr     (rd_cnt),
        .sub     (prdata_reg[15:0]),
        .count   (cnt_val)
    );

    ////////////////////////////////////////////////////////////////////////////
    // event enables and read-clear flags

    logic [7:0] en_next;
    // R03 R04 R05 R06 enable byte write
    assign en_next = wr_ctrl ? pwdata[ppsi_pkg::EN_SHIFT +: 8] : en_reg;

    // R07 R09 enable byte storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg <= ppsi_pkg::EN_RST;
        end else begin
            en_reg <= en_next;
        end
    end

    // R11 clear only what the read returned
    wire logic [7:0] flag_clr = rd_ctrl ? prdata_reg[7:0] : 8'h00;

    // R14 latch independent of enable
    ppsi_sticky_flags #(
        .WIDTH   (8),
        .RST_VAL (ppsi_pkg::FLAGS_RST)
    ) u_ev_flags (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (ev_vec),
        .clr     (flag_clr),
        .flags   (ev_flags)
    );

    // R14 port request
    assign port_irq_req = |(ev_flags & en_reg);

    ////////////////////////////////////////////////////////////////////////////
    // write-one-to-clear status and mask for the summary interrupt

    wire logic [7:0] status_clr = wr_status ? pwdata[7:0] : 8'h00;

    ppsi_sticky_flags #(
        .WIDTH   (8),
        .RST_VAL (ppsi_pkg::FLAGS_RST)
    ) u_irq_status (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (ev_vec),
        .clr     (status_clr),
        .flags   (irq_status)
    );

    logic [7:0] mask_next;
    assign mask_next = wr_mask ? pwdata[7:0] : mask_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= ppsi_pkg::MASK_RST;
        end else begin
            mask_reg <= mask_next;
        end
    end

    assign irq = |(irq_status & mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // crossover override

    logic [15:0] xover_next;
    logic        mdi_sel_reg;
    logic        mdi_sel_next;
    assign xover_next = wr_xover ? pwdata[15:0] : xover_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xover_reg <= ppsi_pkg::XOVER_RST;
        end else begin
            xover_reg <= xover_next;
        end
    end

    // R12 crossover disable
    assign auto_crossover_en      = ~xover_reg[ppsi_pkg::XO_OFF_BIT];
    assign forced_straight_select = xover_reg[ppsi_pkg::XO_FORCE_BIT];
    // R13 forced mode only while auto off
    assign mdi_sel_next = auto_crossover_en ? auto_mdi_straight : forced_straight_select;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mdi_sel_reg <= 1'b0;
        end else begin
            mdi_sel_reg <= mdi_sel_next;
        end
    end

    assign mdi_straight_sel = mdi_sel_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup_rd(logic hit);
        psel && !penable && !pwrite && hit;
    endsequence

    sequence s_access_rd(logic hit);
        psel && penable && !pwrite && hit;
    endsequence

    property p_en_bit(int b);
        wr_ctrl |=> en_reg[b] == $past(pwdata[b + 8]);
    endproperty

    property p_flag_set(int b);
        ev_vec[b] |=> ev_flags[b];
    endproperty

    a_link_word_read: assert property ( // R01
        s_setup_rd(hit_link) |=> prdata[1:0] == $past({link_status.gig_up, link_status.fast_up})
            && prdata[15:2] == 14'h0000)
        else $error("link status read mismatch");

    a_count_read_clr: assert property ( // R02
        s_setup_rd(hit_cnt && !sym_err_frame) ##1 (s_access_rd(hit_cnt) and !sym_err_frame)
            |=> cnt_val == 16'h0000)
        else $error("counter not cleared by read");

    a_count_saturate: assert property ( // R15
        (cnt_val == 16'hFFFF) && !rd_cnt |=> cnt_val == 16'hFFFF)
        else $error("counter wrapped");

    a_count_incr: assert property ( // R15
        sym_err_frame && !rd_cnt && (cnt_val != 16'hFFFF) |=> cnt_val == $past(cnt_val) + 16'h0001)
        else $error("errored frame not counted once");

    a_count_hold: assert property ( // R15
        !sym_err_frame && !rd_cnt |=> $stable(cnt_val))
        else $error("counter moved without frame");

    a_en_jabber: assert property (p_en_bit(7)) // R03
        else $error("jabber enable not written");
    a_en_rx_error: assert property (p_en_bit(6)) // R04
        else $error("receive error enable not written");
    a_en_page_rx: assert property (p_en_bit(5)) // R05
        else $error("page received enable not written");
    a_en_par_fault: assert property (p_en_bit(4)) // R06
        else $error("parallel fault enable not written");
    a_en_lp_ack: assert property (p_en_bit(3)) // R07
        else $error("partner acknowledge enable not written");
    a_en_link_down: assert property (p_en_bit(2)) // R08
        else $error("link down enable not written");
    a_en_rem_fault: assert property (p_en_bit(1)) // R09
        else $error("remote fault enable not written");
    a_en_link_up: assert property (p_en_bit(0)) // R10
        else $error("link up enable not written");

    a_link_down_flag: assert property ( // R08
        link_prev_reg && !link_any |=> ev_flags[ppsi_pkg::EV_LINK_DOWN] && irq_status[2])
        else $error("link loss not flagged");

    a_link_up_flag: assert property ( // R10
        !link_prev_reg && link_any |=> ev_flags[ppsi_pkg::EV_LINK_UP])
        else $error("link gain not flagged");

    a_jabber_flag: assert property (p_flag_set(7)) // R03
        else $error("jabber not flagged");

    a_flags_rd_clr: assert property ( // R11
        s_setup_rd(hit_ctrl && ev_vec == 8'h00) ##1 (s_access_rd(hit_ctrl) and ev_vec == 8'h00)
            |=> ev_flags == 8'h00)
        else $error("event flags not cleared by read");

    a_flags_no_wr: assert property ( // R11
        wr_ctrl && ev_vec == 8'h00 |=> ev_flags == $past(ev_flags))
        else $error("event flags changed by write");

    a_port_req: assert property ( // R14
        (ev_vec & en_next) != 8'h00 |=> port_irq_req)
        else $error("port request not raised");

    a_latch_masked: assert property ( // R14
        en_reg == 8'h00 && !wr_ctrl && ev_vec[ppsi_pkg::EV_RX_ERROR]
            |=> ev_flags[ppsi_pkg::EV_RX_ERROR] && !port_irq_req)
        else $error("masked event not latched or request raised");

    a_auto_follow: assert property ( // R12
        !xover_reg[6] |=> mdi_straight_sel == $past(auto_mdi_straight))
        else $error("auto crossover not followed");

    a_forced_mode: assert property ( // R13
        xover_reg[6] |-> !auto_crossover_en ##1 mdi_straight_sel == $past(xover_reg[7]))
        else $error("forced crossover mode wrong");

endmodule : ppsi_port_regs
`default_nettype wire

// [core/ppsi_sat_counter.sv]
// saturating event counter with subtract-on-clear
`timescale 1ns/1ps
`default_nettype none
module ppsi_sat_counter #(
    parameter int               WIDTH   = 16,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             inc,
    input  wire logic             clr,
    input  wire logic [WIDTH-1:0] sub,
    output logic      [WIDTH-1:0] count
);

    localparam logic [WIDTH-1:0] MAX_VAL = '1;

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] base;
    logic [WIDTH-1:0] count_next;

    // only the value software saw is removed, later frames survive
    assign base       = clr ? WIDTH'(count_reg - sub) : count_reg;
    assign count_next = (inc && (base != MAX_VAL)) ? WIDTH'(base + 1'b1) : base;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= RST_VAL;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;

endmodule : ppsi_sat_counter
`default_nettype wire

// [core/ppsi_sticky_flags.sv]
// bank of sticky flags, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module ppsi_sticky_flags #(
    parameter int               WIDTH   = 8,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] set,
    input  wire logic [WIDTH-1:0] clr,
    output logic      [WIDTH-1:0] flags
);

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_flag
            logic flag_reg;
            logic flag_next;
            assign flag_next = set[gi] | (flag_reg & ~clr[gi]);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flag_reg <= RST_VAL[gi];
                end else begin
                    flag_reg <= flag_next;
                end
            end
            assign flags[gi] = flag_reg;
        end
    endgenerate

endmodule : ppsi_sticky_flags
`default_nettype wire

// [dv/ppsi_link_partner.sv]
// link partner model: link levels, event pulses, errored frames, resolver result
`timescale 1ns/1ps
`default_nettype none
module ppsi_link_partner (
    input  wire logic                  pclk,
    output ppsi_pkg::ppsi_link_t       link_status,
    output ppsi_pkg::ppsi_phy_events_t phy_events,
    output logic                       sym_err_frame,
    output logic                       auto_mdi_straight
);
    logic [2:0] phase_reg = 3'h0;

    initial begin
        link_status = '0;
        phy_events = '0;
        sym_err_frame = 1'b0;
        auto_mdi_straight = 1'b0;
    end

    // resolver result keeps moving so the forced path is exercised
    always @(posedge pclk) begin
        phase_reg <= phase_reg + 3'h1;
        auto_mdi_straight <= phase_reg[2];
    end

    task automatic stim(input logic [5:0] ev, input logic gig, input logic fast);
        @(posedge pclk);
        phy_events <= ev;
        link_status <= {gig, fast};
        @(posedge pclk);
        phy_events <= '0;
    endtask : stim

    // one errored frame per cycle while high
    task automatic frames(input int n);
        @(posedge pclk);
        sym_err_frame <= 1'b1;
        repeat (n) @(posedge pclk);
        sym_err_frame <= 1'b0;
    endtask : frames
endmodule : ppsi_link_partner
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the per-port register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [11:0] A_LS  = {ppsi_pkg::IDX_LINK_STATUS, 2'b00};
    localparam logic [11:0] A_CNT = {ppsi_pkg::IDX_SYM_ERR_COUNT, 2'b00};
    localparam logic [11:0] A_CTL = {ppsi_pkg::IDX_EVENT_CTRL, 2'b00};
    localparam logic [11:0] A_XO  = {ppsi_pkg::IDX_XOVER, 2'b00};
    localparam logic [11:0] A_ST  = {ppsi_pkg::IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] A_MSK = {ppsi_pkg::IDX_IRQ_MASK, 2'b00};
    localparam logic [11:0] RA [6] = '{A_LS, A_CNT, A_CTL, A_XO, A_ST, A_MSK};
    localparam logic [15:0] RV [6] = '{16'h0, 16'h0, 16'h0, 16'h2400, 16'h0, 16'h0};
    localparam logic [15:0] XO_T [4] = '{16'h00c0, 16'h0040, 16'h0000, 16'h2480};

    logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]                paddr;
    logic [31:0]                pwdata, prdata, rd, r;
    ppsi_pkg::ppsi_link_t       link_status;
    ppsi_pkg::ppsi_phy_events_t phy_events;
    logic                       sym_err_frame, auto_mdi_straight, auto_crossover_en;
    logic                       forced_straight_select, mdi_straight_sel, port_irq_req, irq;
    logic                       err, g, f, lg, lf, up, dn, p_auto, p_en, p_force, p_rst;
    logic [7:0]                 en, m, exp;
    logic [5:0]                 ev;
    int                         err_total = 0;
    int                         checks_done = 0;
    int                         cycles = 0;
    int                         n;
    integer                     seed = 32'hc26f;

    ppsi_port_regs #(.ADDR_W(12)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_status(link_status), .phy_events(phy_events), .sym_err_frame(sym_err_frame),
        .auto_mdi_straight(auto_mdi_straight), .auto_crossover_en(auto_crossover_en),
        .forced_straight_select(forced_straight_select), .mdi_straight_sel(mdi_straight_sel),
        .port_irq_req(port_irq_req), .irq(irq));

    ppsi_link_partner lp (.pclk(pclk), .link_status(link_status), .phy_events(phy_events),
        .sym_err_frame(sym_err_frame), .auto_mdi_straight(auto_mdi_straight));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task report_and_stop;
        if (err_total == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] got);
        checks_done++;
        if (got !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, e, got);
        end
    endtask : chk

    task automatic chkb(input string name, input logic e, input logic got);
        chk(name, {31'h0, e}, {31'h0, got});
    endtask : chkb

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 64);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chkb("pready", 1'b1, pready);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
        chkb("pslverr", 1'b0, err);
    endtask : wr

    task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chkb("pslverr", 1'b0, err);
        chk(name, e, rd);
    endtask : rdc

    function automatic logic [7:0] ev_flags(input logic [5:0] e, input logic u, input logic d);
        return {e[5:1], d, e[0], u};
    endfunction : ev_flags

    always @(posedge pclk) begin
        cycles++;
        p_auto = auto_mdi_straight;
        p_en = auto_crossover_en;
        p_force = forced_straight_select;
        p_rst = presetn;
        if (cycles == 90000) begin
            err_total++;
            report_and_stop();
        end
    end

    always @(negedge pclk) begin
        if (p_rst === 1'b1 && presetn === 1'b1) chkb("mdi_sel", p_en ? p_auto : p_force, mdi_straight_sel);
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        lg = 1'b0;
        lf = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) rdc("reset", RA[i], {16'h0, RV[i]});
        for (int i = 0; i < 14; i++) begin
            r = $random(seed);
            {f, g, ev, m, en} = r[23:0];
            if (i == 0) {ev, g, f, en, m} = {6'h3f, 2'b10, 16'hffff};
            if (i == 1) {ev, g, f, en} = {6'h10, 10'h000};
            up = !(lg | lf) && (g | f);
            dn = (lg | lf) && !(g | f);
            exp = ev_flags(ev, up, dn);
            wr(A_CTL, {16'h0, en, 8'hff});
            wr(A_MSK, {24'h0, m});
            lp.stim(ev, g, f);
            repeat (3) @(posedge pclk);
            chkb("port_irq_req", |(exp & en), port_irq_req);
            chkb("irq", |(exp & m), irq);
            rdc("link", A_LS, {30'h0, g, f});
            rdc("ctl_flags", A_CTL, {16'h0, en, exp});
            rdc("ctl_clear", A_CTL, {16'h0, en, 8'h00});
            chkb("irq_req_clr", 1'b0, port_irq_req);
            rdc("status", A_ST, {24'h0, exp});
            wr(A_ST, {24'h0, exp});
            rdc("status_clr", A_ST, 32'h0);
            chkb("irq_clr", 1'b0, irq);
            lg = g;
            lf = f;
        end
        r = $random(seed);
        n = int'(r[4:0]) + 1;
        lp.frames(n);
        rdc("count", A_CNT, 32'(n));
        rdc("count_clr", A_CNT, 32'h0);
        lp.frames(3);
        wr(A_CNT, 32'hffff);
        wr(A_LS, 32'hffff);
        rdc("count_ro", A_CNT, 32'h3);
        rdc("link_ro", A_LS, {30'h0, lg, lf});
        rdc("count_clr", A_CNT, 32'h0);
        lp.frames(65540);
        rdc("count_sat", A_CNT, 32'hffff);
        rdc("count_clr", A_CNT, 32'h0);
        for (int i = 0; i < 6; i++) begin
            r = $random(seed);
            if (i < 4) r[15:0] = XO_T[i];
            wr(A_XO, {16'h0, r[15:0]});
            rdc("xover", A_XO, {16'h0, r[15:0]});
            chkb("auto_en", ~r[6], auto_crossover_en);
            chkb("forced", r[7], forced_straight_select);
            repeat (8) @(posedge pclk);
        end
        apb(1'b0, 12'h7fc, 32'h0);
        chkb("slverr_unmapped", 1'b1, err);
        chk("unmapped_data", 32'h0, rd);
        apb(1'b0, A_LS + 12'h1, 32'h0);
        chkb("slverr_misaligned", 1'b1, err);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
